// ---- rtl/rti_cfg.svh ----
// How it works
// - select divides fs by 2^14 down to 2^11
// - runs while run bit is set and low-frequency oscillator is enabled
// - tick wakes standby except in stop mode
// - run bit low stops and clears divider
// - eight-bit read-only tick accumulator, resets zero
// - accumulator increments one fs cycle after tick
// - clear ignored within one fs cycle of tick
// - writing zero to bit 3 clears accumulator
`ifndef RTI_CFG_SVH
`define RTI_CFG_SVH

// register byte addresses
`define RTI_CTRL_ADDR      32'hffff_f0a0
`define RTI_ACC_ADDR       32'hffff_f0a4

// control field positions
`define RTI_RUN_BIT        0
`define RTI_SEL_LO_BIT     1
`define RTI_SEL_HI_BIT     2
`define RTI_CLR_BIT        3
`define RTI_MSB_BIT        7

// reset values
`define RTI_CTRL_RESET     8'h00
`define RTI_ACC_RESET      8'h00

// timing: system clock and low-frequency clock rates
`define RTI_ACLK_HZ        125000000
`define RTI_FS_HZ          32768
`define RTI_FS_DIV         ((`RTI_ACLK_HZ + `RTI_FS_HZ / 2) / `RTI_FS_HZ)

// longest period is 2^14 fs cycles
`define RTI_PRESCALE_LAST  14'h3fff

// bus responses
`define RTI_RESP_OKAY      2'b00
`define RTI_RESP_SLVERR    2'b10

`endif

// ---- rtl/rti_pkg.sv ----
package rti_pkg;

  // whole state of the timer block
  typedef struct packed {
    logic        aw_full;
    logic [31:0] aw_addr;
    logic        w_full;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic        run;
    logic [1:0]  sel;
    logic        clr_bit;
    logic [11:0] fs_cnt;
    logic        fs_en;
    logic [13:0] prescale;
    logic        tick;
    logic        wake;
    logic        inc_pend;
    logic [7:0]  acc;
  } rti_state_s;

endpackage

// ---- rtl/rti_interval_timer.sv ----
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rti_cfg.svh"

module rti_interval_timer #(
  parameter int FS_DIV = `RTI_FS_DIV
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        lf_osc_en,
  input  wire logic        stop_mode,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             periodic_tick_interrupt,
  output logic             standby_wake_request,
  output logic [7:0]       interrupt_count_accumulator
);

  // divider counter is 12 bits wide
  if (FS_DIV < 2 || FS_DIV > 4096) begin : g_bad_div
    $error("FS_DIV must lie between 2 and 4096");
  end

  localparam logic [11:0] FS_LAST = 12'(FS_DIV - 1);

  // last prescaler count for the selected period
  function automatic logic [13:0] period_last(input logic [1:0] sel);
    period_last = `RTI_PRESCALE_LAST >> sel;
  endfunction

  // control register readback, reserved bits zero
  function automatic logic [7:0] ctrl_view(input rti_pkg::rti_state_s s);
    ctrl_view = {4'h0, s.clr_bit, s.sel, s.run};
  endfunction

  rti_pkg::rti_state_s st_q;
  rti_pkg::rti_state_s st_d;
  logic                wr_fire;
  logic                rd_fire;
  logic                clr_req;

  // next-state logic for bus, divider and accumulator
  always_comb begin
    st_d    = st_q;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    clr_req = 1'b0;

    // write address and data taken in either order
    if (s_axi_awvalid && st_q.aw_rdy) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.w_rdy) begin
      st_d.w_full  = 1'b1;
      st_d.w_data  = s_axi_wdata[7:0];
      st_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // both halves present: perform the write
    if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
      wr_fire      = 1'b1;
      st_d.aw_full = 1'b0;
      st_d.w_full  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = `RTI_RESP_OKAY;
      if (st_q.aw_addr == `RTI_CTRL_ADDR) begin
        if (st_q.w_lane0) begin
          st_d.run     = st_q.w_data[`RTI_RUN_BIT];
          st_d.sel     = {st_q.w_data[`RTI_SEL_HI_BIT], st_q.w_data[`RTI_SEL_LO_BIT]};
          st_d.clr_bit = st_q.w_data[`RTI_CLR_BIT];
          clr_req      = !st_q.w_data[`RTI_CLR_BIT];
        end
      end else if (st_q.aw_addr != `RTI_ACC_ADDR) begin
        st_d.bresp = `RTI_RESP_SLVERR;
      end
    end

    // read answered the cycle after the address is taken
    if (s_axi_rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_q.ar_rdy) begin
      rd_fire     = 1'b1;
      st_d.rvalid = 1'b1;
      st_d.rresp  = `RTI_RESP_OKAY;
      if (s_axi_araddr == `RTI_CTRL_ADDR) begin
        st_d.rdata = ctrl_view(st_q);
      end else if (s_axi_araddr == `RTI_ACC_ADDR) begin
        st_d.rdata = st_q.acc;
      end else begin
        st_d.rdata = 8'h00;
        st_d.rresp = `RTI_RESP_SLVERR;
      end
    end

    // fs enable derived from the system clock, only while oscillating
    st_d.fs_en = 1'b0;
    if (!lf_osc_en) begin
      st_d.fs_cnt = 12'h000;
    end else if (st_q.fs_cnt == FS_LAST) begin
      st_d.fs_cnt = 12'h000;
      st_d.fs_en  = 1'b1;
    end else begin
      st_d.fs_cnt = st_q.fs_cnt + 12'h001;
    end

    // tick lasts one fs cycle, increment lands one fs cycle later
    if (st_q.fs_en) begin
      st_d.tick = 1'b0;
      st_d.wake = 1'b0;
      if (st_q.inc_pend) begin
        st_d.inc_pend = 1'b0;
        st_d.acc      = st_q.acc + 8'h01;
      end
    end

    // prescaler toward the selected period
    if (!st_q.run) begin
      st_d.prescale = 14'h0000;
    end else if (st_q.fs_en) begin
      if (st_q.prescale >= period_last(st_q.sel)) begin
        st_d.prescale = 14'h0000;
        st_d.tick     = 1'b1;
        st_d.wake     = !stop_mode;
        st_d.inc_pend = 1'b1;
      end else begin
        st_d.prescale = st_q.prescale + 14'h0001;
      end
    end

    // clear refused while an increment is still pending
    if (clr_req && !st_q.inc_pend && !st_d.inc_pend) begin
      st_d.acc = `RTI_ACC_RESET;
    end

    // ready flags kept in flops
    st_d.aw_rdy = !st_d.aw_full && !st_d.bvalid;
    st_d.w_rdy  = !st_d.w_full && !st_d.bvalid;
    st_d.ar_rdy = !st_d.rvalid;
  end

  // register the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q         <= '0;
      st_q.run     <= 1'(`RTI_CTRL_RESET >> `RTI_RUN_BIT);
      st_q.acc     <= `RTI_ACC_RESET;
      st_q.aw_rdy  <= 1'b1;
      st_q.w_rdy   <= 1'b1;
      st_q.ar_rdy  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state flops
  assign s_axi_awready               = st_q.aw_rdy;
  assign s_axi_wready                = st_q.w_rdy;
  assign s_axi_bvalid                = st_q.bvalid;
  assign s_axi_bresp                 = st_q.bresp;
  assign s_axi_arready               = st_q.ar_rdy;
  assign s_axi_rvalid                = st_q.rvalid;
  assign s_axi_rresp                 = st_q.rresp;
  assign s_axi_rdata                 = {24'h00_0000, st_q.rdata};
  assign periodic_tick_interrupt     = st_q.tick;
  assign standby_wake_request        = st_q.wake;
  assign interrupt_count_accumulator = st_q.acc;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tick_rise_fs:  assert property ($rose(st_q.tick) |-> $past(st_q.fs_en) && $past(st_q.run))
    else $error("tick rose without fs enable while running");
  a_tick_period:   assert property ($rose(st_q.tick) |-> $past(st_q.prescale) == $past(period_last(st_q.sel)))
    else $error("tick not at selected period");
  a_fs_needs_osc:  assert property (!lf_osc_en |=> !st_q.fs_en)
    else $error("fs enable without oscillator");
  a_wake_no_stop:  assert property ($rose(st_q.wake) |-> $past(!stop_mode) && st_q.tick)
    else $error("wake raised in stop mode");
  a_run_clears:    assert property (!st_q.run |=> st_q.prescale == 14'h0000)
    else $error("prescaler not cleared while stopped");
  a_inc_pending:   assert property ($rose(st_q.tick) |-> st_q.inc_pend && st_q.acc == $past(st_q.acc))
    else $error("increment not deferred");
  a_acc_step:      assert property (st_q.fs_en && st_q.inc_pend |=> st_q.acc == $past(st_q.acc) + 8'h01)
    else $error("accumulator did not step");
  a_clr_blocked:   assert property (clr_req && st_q.inc_pend |=> st_q.acc != 8'h00 || $past(st_q.acc) == 8'hff
                                    || $past(st_q.acc) == 8'h00)
    else $error("clear accepted during blocked window");
  a_clr_works:     assert property (clr_req && !st_q.inc_pend && !st_d.inc_pend |=> st_q.acc == 8'h00)
    else $error("clear did not take");
  a_tick_one_fs:   assert property (st_q.tick && st_q.fs_en |=> !st_q.tick)
    else $error("tick outlived one fs cycle");
  a_write_answer:  assert property (st_q.aw_full && st_q.w_full && !st_q.bvalid |=> st_q.bvalid)
    else $error("write not answered");
  a_read_answer:   assert property (rd_fire |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read not answered");

  // helper: aclk cycles the tick has stood
  logic [12:0] tick_age_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !st_q.tick) begin
      tick_age_q <= 13'h0000;
    end else if (tick_age_q != 13'h1fff) begin
      tick_age_q <= tick_age_q + 13'h0001;
    end
  end

  // tick and wake pulse shape
  a_tick_width:    assert property (st_q.tick |-> tick_age_q < 13'(FS_DIV))
    else $error("tick stood longer than one fs cycle");
  a_fs_spacing:    assert property (st_q.fs_en |=> !st_q.fs_en)
    else $error("fs enable on two cycles in a row");
  a_stopped_quiet: assert property (!st_q.run |=> !$rose(st_q.tick))
    else $error("tick rose while stopped");
  a_wake_has_tick: assert property (st_q.wake |-> st_q.tick)
    else $error("wake without tick");
  a_stop_no_wake:  assert property ($rose(st_q.tick) && $past(stop_mode) |-> !st_q.wake)
    else $error("wake raised in stop mode");

  // accumulator moves only by step or clear
  a_acc_only_step: assert property (!(st_q.fs_en && st_q.inc_pend) && !clr_req |=> $stable(st_q.acc))
    else $error("accumulator changed without cause");
  a_acc_ro_write:  assert property (wr_fire && st_q.aw_addr == `RTI_ACC_ADDR && !(st_q.fs_en && st_q.inc_pend)
                                    |=> $stable(st_q.acc))
    else $error("accumulator written by bus");
  a_acc_wrap:      assert property (st_q.fs_en && st_q.inc_pend && st_q.acc == 8'hff |=> st_q.acc == 8'h00)
    else $error("accumulator did not wrap");
  a_clr_one_kept:  assert property (wr_fire && st_q.aw_addr == `RTI_CTRL_ADDR && st_q.w_lane0
                                    && st_q.w_data[`RTI_CLR_BIT] && !(st_q.fs_en && st_q.inc_pend)
                                    |=> $stable(st_q.acc))
    else $error("clear bit one changed accumulator");

  // control register contents
  a_ctrl_msb_zero: assert property (rd_fire && s_axi_araddr == `RTI_CTRL_ADDR
                                    |=> s_axi_rdata[`RTI_MSB_BIT] == 1'b0)
    else $error("control bit 7 read as one");
  a_run_stored:    assert property (wr_fire && st_q.aw_addr == `RTI_CTRL_ADDR && st_q.w_lane0
                                    |=> st_q.run == $past(st_q.w_data[`RTI_RUN_BIT]))
    else $error("run bit not stored");

  // bus answers hold and decode
  a_rdata_upper:   assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_r_hold:        assert property (s_axi_rvalid && !s_axi_rready
                                    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer not held");
  a_b_hold:        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  a_wr_blocked:    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_rd_blocked:    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_bad_raddr:     assert property (rd_fire && s_axi_araddr != `RTI_CTRL_ADDR && s_axi_araddr != `RTI_ACC_ADDR
                                    |=> s_axi_rresp == `RTI_RESP_SLVERR)
    else $error("unmapped read not refused");
  a_bad_waddr:     assert property (wr_fire && st_q.aw_addr != `RTI_CTRL_ADDR && st_q.aw_addr != `RTI_ACC_ADDR
                                    |=> s_axi_bresp == `RTI_RESP_SLVERR)
    else $error("unmapped write not refused");

endmodule // rti_interval_timer

// ---- dv/tb_rti_interval_timer.sv ----
`timescale 1ns/1ps
`include "rti_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_rti_interval_timer;
  localparam int FSD = 2;
  logic        aclk = 0, aresetn = 0, lf_osc_en = 1, stop_mode = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        periodic_tick_interrupt, standby_wake_request;
  logic [7:0]  interrupt_count_accumulator;
  logic [31:0] d;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0;

  rti_interval_timer #(.FS_DIV(FSD)) dut (.aclk, .aresetn, .lf_osc_en, .stop_mode, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periodic_tick_interrupt,
    .standby_wake_request, .interrupt_count_accumulator);

  // 125 MHz clock
  always #4 aclk = ~aclk;

  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one write, waits for the response
  task automatic wr(input logic [31:0] a, input logic [7:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // one read, waits for the data
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // restart at a select, time the first tick, its width, wake and count step
  task automatic measure(input logic [1:0] sel, input logic stp);
    int n, m, per;
    logic [7:0] a0;
    per = (2 ** (14 - sel)) * FSD;
    stop_mode <= stp;
    wr(`RTI_CTRL_ADDR, 8'h08, r);
    wr(`RTI_CTRL_ADDR, {4'h0, 1'b1, sel, 1'b1}, r);
    a0 = interrupt_count_accumulator;
    n = 0;
    while (periodic_tick_interrupt !== 1'b1 && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    `CHK("period", 1'b1, (n >= per - 2 * FSD - 4) && (n <= per + 2 * FSD + 4))
    `CHK("wake", ~stp, standby_wake_request)
    `CHK("acc_hold", a0, interrupt_count_accumulator)
    m = 0;
    while (periodic_tick_interrupt === 1'b1 && m < 100) begin
      @(posedge aclk);
      m++;
    end
    `CHK("width", FSD, m)
    `CHK("acc_inc", a0 + 8'h01, interrupt_count_accumulator)
  endtask

  // no tick may appear for a while
  task automatic quiet();
    int k;
    k = 0;
    repeat (5000) begin
      @(posedge aclk);
      if (periodic_tick_interrupt !== 1'b0) k++;
    end
    `CHK("quiet", 0, k)
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`RTI_CTRL_ADDR, d, r);
    `CHK("ctrl_rst", 32'h0000_0000, d)
    rd(`RTI_ACC_ADDR, d, r);
    `CHK("acc_rst", 32'h0000_0000, d)
    rd(32'h0000_0010, d, r);
    `CHK("unmapped", `RTI_RESP_SLVERR, r)
    wr(`RTI_ACC_ADDR, 8'h55, r);
    `CHK("acc_wr", `RTI_RESP_OKAY, r)
    for (int s = 3; s >= 0; s--) measure(s[1:0], 1'b0);
    rd(`RTI_CTRL_ADDR, d, r);
    `CHK("ctrl_rd", 32'h0000_0009, d)
    rd(`RTI_ACC_ADDR, d, r);
    `CHK("acc_rd", 32'h0000_0004, d)
    measure(2'b11, 1'b1);
    stop_mode <= 1'b0;
    wr(`RTI_CTRL_ADDR, 8'h08, r);
    quiet();
    lf_osc_en <= 1'b0;
    wr(`RTI_CTRL_ADDR, 8'h0f, r);
    quiet();
    wr(`RTI_CTRL_ADDR, 8'h08, r);
    lf_osc_en <= 1'b1;
    `CHK("no_clr", 8'h05, interrupt_count_accumulator)
    wr(`RTI_CTRL_ADDR, 8'h00, r);
    wr(`RTI_CTRL_ADDR, 8'h00, r);
    rd(`RTI_ACC_ADDR, d, r);
    `CHK("clr", 32'h0000_0000, d)
    report_and_stop();
  end
endmodule // tb_rti_interval_timer
